//--- logic/serdes_pkg.sv
// What this block does
// - rx b byte: first bit at 0, read-only
// - rx b qualifier: read-only, ones mark valid bits
// - all-valid status implies all eight bits valid
// - mask bits: underflow 3, overflow 2, done 1, empty 0
// - underflow when sending with holding register empty
// - overflow when host writes before shift load
// - done when all data sent, nothing waiting
// - empty when holding byte moves to shifter
// - status read-only, same flags, upper reserved
// - flag reads one while pending
// - underflow set when sampling with no data
// - overflow set on early load, read clears
// - done set when byte finished, none queued
// - done needs one sent bit, read clears
// - data write clears empty flag
// - empty set again on shifter load
// - flags set regardless of mask
// - flags read zero outside transmit mode
// - qualifier picks data or preamble, lsb first
//
// Purpose: constants and types for the serializer status block
// Assumes: byte-wide host register port, one clock
// Notes:   all offsets are byte register addresses of the host port
package serdes_pkg;
    localparam logic [7:0] ADDR_RX_B_BYTE  = 8'h0b;
    localparam logic [7:0] ADDR_RX_B_QUAL  = 8'h0c;
    localparam logic [7:0] ADDR_TX_MASK    = 8'h0d;
    localparam logic [7:0] ADDR_TX_FLAGS   = 8'h0e;
    localparam logic [7:0] ADDR_TX_DATA    = 8'h0f;
    localparam logic [7:0] ADDR_TX_QUAL    = 8'h10;
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [3:0] RST_FLAGS       = 4'h0;
    localparam int         BIT_UNDERFLOW   = 3;
    localparam int         BIT_OVERFLOW    = 2;
    localparam int         BIT_DONE        = 1;
    localparam int         BIT_EMPTY       = 0;
    localparam int         FLAG_W          = 4;
    // host register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_s;
    // received channel b byte with per-bit qualifier
    typedef struct packed {
        logic       load;
        logic [7:0] data;
        logic [7:0] qual;
    } rx_b_s;
    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_e;
endpackage

//--- logic/serdes_status.sv
// Purpose: rx channel b byte registers and transmit holding/interrupt flags
// Assumes: host port gives one-cycle rd/wr strobes; read data registered
// Notes:   flags are forced to zero outside transmit mode
`timescale 1ns/1ps
module serdes_status (
    input  wire logic                  clk_sys_i,   // system clock
    input  wire logic                  rst_b_i,     // async reset, active low
    input  wire serdes_pkg::host_req_s host_i,      // host register request
    output logic [7:0]                 rdata_o,     // registered read data
    input  wire serdes_pkg::rx_b_s     rx_b_i,      // received channel b byte
    output logic                       rx_b_all_o,  // all bits of rx b valid
    input  wire logic                  tx_mode_i,   // transmit enable
    input  wire logic                  bit_en_i,    // bit time strobe
    output logic                       tx_bit_o,    // serial transmit bit
    output logic                       tx_data_o,   // bit is data, not preamble
    output logic                       irq_o        // interrupt, active high
);
    typedef struct packed {
        logic [7:0]                      rx_byte;
        logic [7:0]                      rx_qual;
        logic                            rx_all;
        logic [3:0]                      mask;
        logic [3:0]                      flags;
        logic [7:0]                      hold;
        logic [7:0]                      hold_qual;
        logic [7:0]                      tx_qual;
        logic                            full;
        logic                            any_sent;
        serdes_pkg::tx_state_e           st;
        logic [7:0]                      rdata;
    } st_s;
    st_s cur_ff;
    st_s nxt_cur;

    logic       sh_busy;
    logic       sh_last;
    logic       sh_sent;
    logic       sh_load;
    logic       wr_data;
    logic       wr_qual;
    logic       rd_flags;
    logic [3:0] set_f;

    assign wr_data  = host_i.wr && (host_i.addr == serdes_pkg::ADDR_TX_DATA);
    assign wr_qual  = host_i.wr && (host_i.addr == serdes_pkg::ADDR_TX_QUAL);
    assign rd_flags = host_i.rd && (host_i.addr == serdes_pkg::ADDR_TX_FLAGS);
    // load the shifter when a byte waits and the shifter is idle or finishing
    assign sh_load  = tx_mode_i && cur_ff.full && (!sh_busy || (bit_en_i && sh_last));

    tx_shifter u_shf (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .bit_en_i   (bit_en_i),
        .load_i     (sh_load),
        .data_i     (cur_ff.hold),
        .qual_i     (cur_ff.hold_qual),
        .busy_o     (sh_busy),
        .last_o     (sh_last),
        .bit_o      (tx_bit_o),
        .bit_data_o (tx_data_o),
        .sent_o     (sh_sent)
    );

    always_comb begin
        nxt_cur = cur_ff;
        set_f   = 4'h0;
        if (rx_b_i.load) begin
            nxt_cur.rx_byte = rx_b_i.data;
            nxt_cur.rx_qual = rx_b_i.qual;
            nxt_cur.rx_all  = &rx_b_i.qual;
        end
        if (host_i.wr && host_i.addr == serdes_pkg::ADDR_TX_MASK) begin
            nxt_cur.mask = host_i.wdata[3:0];
        end
        if (wr_qual) begin
            nxt_cur.tx_qual = host_i.wdata;
        end
        // detections; mask does not gate them
        set_f[serdes_pkg::BIT_OVERFLOW]  = wr_data && cur_ff.full && !sh_load;
        set_f[serdes_pkg::BIT_UNDERFLOW] = cur_ff.st == serdes_pkg::TX_SHIFT && bit_en_i
                                           && !sh_busy && !cur_ff.full;
        set_f[serdes_pkg::BIT_DONE]      = sh_sent && !sh_busy && !cur_ff.full
                                           && cur_ff.any_sent;
        set_f[serdes_pkg::BIT_EMPTY]     = sh_load;
        if (wr_data) begin
            nxt_cur.hold      = host_i.wdata;
            nxt_cur.hold_qual = wr_qual ? host_i.wdata : cur_ff.tx_qual;
            nxt_cur.full      = 1'b1;
        end else if (sh_load) begin
            nxt_cur.full = 1'b0;
        end
        if (sh_sent) begin
            nxt_cur.any_sent = 1'b1;
        end
        // once sending has begun, every later bit time without data is an underflow
        case (cur_ff.st)
            serdes_pkg::TX_IDLE: begin
                if (sh_load) begin
                    nxt_cur.st = serdes_pkg::TX_SHIFT;
                end
            end
            serdes_pkg::TX_SHIFT: begin
                nxt_cur.st = serdes_pkg::TX_SHIFT;             // left only when transmit mode drops
            end
            default: nxt_cur.st = serdes_pkg::TX_IDLE;
        endcase
        // reads clear overflow, done, underflow; new events win over the clear
        if (rd_flags) begin
            nxt_cur.flags[serdes_pkg::BIT_OVERFLOW]  = 1'b0;
            nxt_cur.flags[serdes_pkg::BIT_DONE]      = 1'b0;
            nxt_cur.flags[serdes_pkg::BIT_UNDERFLOW] = 1'b0;
        end
        if (wr_data) begin
            nxt_cur.flags[serdes_pkg::BIT_EMPTY] = 1'b0;
        end
        nxt_cur.flags = nxt_cur.flags | set_f;
        if (!tx_mode_i) begin
            nxt_cur.flags    = serdes_pkg::RST_FLAGS;
            nxt_cur.any_sent = 1'b0;
            nxt_cur.st       = serdes_pkg::TX_IDLE;
        end
        nxt_cur.rdata = serdes_pkg::RST_BYTE;
        if (host_i.rd) begin
            case (host_i.addr)
                serdes_pkg::ADDR_RX_B_BYTE: nxt_cur.rdata = cur_ff.rx_byte;
                serdes_pkg::ADDR_RX_B_QUAL: nxt_cur.rdata = cur_ff.rx_qual;
                serdes_pkg::ADDR_TX_MASK:   nxt_cur.rdata = {4'h0, cur_ff.mask};
                serdes_pkg::ADDR_TX_FLAGS:  nxt_cur.rdata = {4'h0, cur_ff.flags};
                serdes_pkg::ADDR_TX_DATA:   nxt_cur.rdata = cur_ff.hold;
                serdes_pkg::ADDR_TX_QUAL:   nxt_cur.rdata = cur_ff.tx_qual;
                default:                    nxt_cur.rdata = serdes_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_ff    <= '0;
            cur_ff.st <= serdes_pkg::TX_IDLE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign rdata_o    = cur_ff.rdata;
    assign rx_b_all_o = cur_ff.rx_all;
    assign irq_o      = |(cur_ff.flags & cur_ff.mask);
endmodule // serdes_status

//--- logic/tx_shifter.sv
// Purpose: transmit shift register, sends qualified bits lsb first
// Assumes: bit_en_i is a one-cycle bit-time strobe
// Notes:   a bit whose qualifier is zero is sent as preamble if a higher bit is qualified
`timescale 1ns/1ps
module tx_shifter (
    input  wire logic       clk_sys_i,   // system clock
    input  wire logic       rst_b_i,     // async reset, active low
    input  wire logic       bit_en_i,    // bit time strobe
    input  wire logic       load_i,      // load new byte this cycle
    input  wire logic [7:0] data_i,      // byte to load
    input  wire logic [7:0] qual_i,      // qualifier to load
    output logic            busy_o,      // qualified bits remain
    output logic            last_o,      // current bit is last qualified
    output logic            bit_o,       // serial bit
    output logic            bit_data_o,  // high: data, low: preamble
    output logic            sent_o       // one bit went out
);
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] qual;
        logic       bit_q;
        logic       is_data;
        logic       sent;
    } shf_s;
    shf_s cur_ff;
    shf_s nxt_cur;

    assign busy_o = |cur_ff.qual;
    assign last_o = (cur_ff.qual[7:1] == 7'h00);

    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.sent = 1'b0;
        if (bit_en_i && busy_o) begin
            nxt_cur.bit_q   = cur_ff.data[0];
            nxt_cur.is_data = cur_ff.qual[0];
            nxt_cur.data    = {1'b0, cur_ff.data[7:1]};
            nxt_cur.qual    = {1'b0, cur_ff.qual[7:1]};
            nxt_cur.sent    = 1'b1;
        end
        // a load in the last bit time must not swallow that last bit
        if (load_i) begin
            nxt_cur.data = data_i;
            nxt_cur.qual = qual_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign bit_o      = cur_ff.bit_q;
    assign bit_data_o = cur_ff.is_data;
    assign sent_o     = cur_ff.sent;
endmodule // tx_shifter

//--- sim/host_model.sv
// Purpose: host side of the register port
// Assumes: one-cycle strobes, read data one cycle after the read edge
// Notes:   idle address and data are inverted so stale values never look valid
`timescale 1ns/1ps
module host_model (
    input  wire logic             clk_sys_i, // clock
    input  wire logic [7:0]       rdata_i,   // read data
    output serdes_pkg::host_req_s host_o     // host request
);
    initial host_o = '0;
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        host_o = '{1'b1, 1'b0, a, (a == serdes_pkg::ADDR_TX_MASK) ? {4'h0, d[3:0]} : d};
        @(negedge clk_sys_i);
        host_o = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        host_o = '{1'b0, 1'b1, a, 8'h5a};
        // read data stands only in the cycle after the read edge
        @(negedge clk_sys_i);
        d = rdata_i;
        host_o = '{1'b0, 1'b0, ~a, 8'ha5};
        @(negedge clk_sys_i);
    endtask
endmodule // host_model

//--- sim/serdes_status_chk.sv
// Purpose: port assertions for serdes_status
// Assumes: host rd/wr are one-cycle pulses
// Notes:   mask is shadowed from host writes since the checker cannot see it
`timescale 1ns/1ps
module serdes_status_chk (
    input wire logic                  clk_sys_i,  // clock
    input wire logic                  rst_b_i,    // reset, active low
    input wire serdes_pkg::host_req_s host_i,     // host request
    input wire logic [7:0]            rdata_o,    // read data
    input wire serdes_pkg::rx_b_s     rx_b_i,     // rx b input
    input wire logic                  rx_b_all_o, // all bits valid
    input wire logic                  tx_mode_i,  // transmit enable
    input wire logic                  bit_en_i,   // bit strobe
    input wire logic                  irq_o       // interrupt
);
    logic [3:0] mask_ff;
    logic       mk_rd;
    logic       st_rd;
    logic       quiet;
    assign mk_rd = host_i.rd && host_i.addr == serdes_pkg::ADDR_TX_MASK;
    assign st_rd = host_i.rd && host_i.addr == serdes_pkg::ADDR_TX_FLAGS;
    // a strobe or write could set a flag again, so clear checks need neither
    assign quiet = !bit_en_i && !host_i.wr;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i)
            mask_ff <= 4'h0;
        else if (host_i.wr && host_i.addr == serdes_pkg::ADDR_TX_MASK)
            mask_ff <= host_i.wdata[3:0];
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    a_rdata_idle: assert property (!$past(host_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_mask_read: assert property ($past(mk_rd) |-> rdata_o == {4'h0, $past(mask_ff)})
        else $error("mask read wrong");
    a_flag_upper: assert property ($past(st_rd) |-> rdata_o[7:4] == 4'h0)
        else $error("flag upper bits set");
    a_flags_off: assert property ($past(st_rd) && !$past(tx_mode_i) && !$past(tx_mode_i, 2)
        |-> rdata_o == 8'h00)
        else $error("flags outside transmit mode");
    a_irq_off: assert property (!tx_mode_i && !$past(tx_mode_i) |-> !irq_o)
        else $error("irq outside transmit mode");
    a_irq_mask: assert property (irq_o |-> mask_ff != 4'h0)
        else $error("irq with mask clear");
    a_rx_all: assert property ($past(rx_b_i.load) |-> rx_b_all_o == ($past(rx_b_i.qual) == 8'hff))
        else $error("all valid wrong after load");
    a_rx_hold: assert property (!$past(rx_b_i.load) |-> $stable(rx_b_all_o))
        else $error("all valid moved without load");
    a_read_clear: assert property ($past(quiet, 2) && $past(quiet) && st_rd && quiet
        ##1 quiet [*2] ##1 st_rd && quiet |=> rdata_o[3:1] == 3'h0)
        else $error("status read did not clear");
endmodule // serdes_status_chk
bind serdes_status serdes_status_chk i_chk (.clk_sys_i, .rst_b_i, .host_i, .rdata_o, .rx_b_i, .rx_b_all_o,
    .tx_mode_i, .bit_en_i, .irq_o);

//--- sim/serdes_status_tb.sv
// Purpose: self-checking bench for serdes_status
// Assumes: inputs change on the falling edge
// Notes:   preamble bits are checked on the data flag only
`timescale 1ns/1ps
module serdes_status_tb;
    logic                  clk_sys_i, rst_b_i, tx_mode_i, bit_en_i, rx_all, tx_bit, tx_data, irq;
    serdes_pkg::host_req_s host;
    serdes_pkg::rx_b_s     rx_b;
    logic [7:0]            rdata, d, q, v;
    int                    num_errors = 0, check_count = 0, seed = 60, cycles = 0;
    localparam logic [7:0] FL = serdes_pkg::ADDR_TX_FLAGS;
    serdes_status i_serdes_status (.clk_sys_i, .rst_b_i, .host_i(host), .rdata_o(rdata), .rx_b_i(rx_b),
        .rx_b_all_o(rx_all), .tx_mode_i, .bit_en_i, .tx_bit_o(tx_bit), .tx_data_o(tx_data), .irq_o(irq));
    host_model i_host_model (.clk_sys_i, .rdata_i(rdata), .host_o(host));
    function automatic logic [7:0] fl(input logic u, o, n, e);
        return {4'h0, u, o, n, e};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        i_host_model.read(a, r);
        chk(r, exp);
    endtask
    task automatic strobe(input logic eb, input logic ed);
        @(negedge clk_sys_i) bit_en_i = 1'b1;
        @(negedge clk_sys_i) bit_en_i = 1'b0;
        chk({6'h0, tx_data, tx_bit & ed}, {6'h0, ed, eb & ed});
        repeat (3) @(negedge clk_sys_i);
    endtask
    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // cut a hang well beyond the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        {tx_mode_i, bit_en_i, rst_b_i} = 3'b000;
        rx_b = '0;
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rst_b_i = 1'b1;
        for (int i = 8'h0b; i < 8'h10; i++) rd_chk(i[7:0] | 8'h00, 8'h00);
        rd_chk(8'h20, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            q = (i < 2) ? 8'hff : $random(seed);
            @(negedge clk_sys_i) rx_b = '{1'b1, d, q};
            @(negedge clk_sys_i) rx_b = '{1'b0, ~d, ~q};
            chk({7'h0, rx_all}, {7'h0, q == 8'hff});
            i_host_model.write(serdes_pkg::ADDR_RX_B_BYTE, ~d);
            rd_chk(serdes_pkg::ADDR_RX_B_BYTE, d);
            rd_chk(serdes_pkg::ADDR_RX_B_QUAL, q);
        end
        $display("test rx byte done");
        for (int i = 0; i < 7; i++) begin
            v = (i < 4) ? 8'h01 << i : $random(seed);
            i_host_model.write(serdes_pkg::ADDR_TX_MASK, v);
            rd_chk(serdes_pkg::ADDR_TX_MASK, {4'h0, v[3:0]});
        end
        i_host_model.write(FL, 8'hff);
        i_host_model.write(serdes_pkg::ADDR_TX_MASK, 8'h00);
        $display("test mask done");
        tx_mode_i = 1'b1;
        rd_chk(FL, 8'h00);
        d = $random(seed);
        v = $random(seed);
        q = 8'h0b;
        i_host_model.write(serdes_pkg::ADDR_TX_QUAL, q);
        rd_chk(serdes_pkg::ADDR_TX_QUAL, q);
        i_host_model.write(serdes_pkg::ADDR_TX_DATA, d);
        i_host_model.write(serdes_pkg::ADDR_TX_DATA, ~d);
        i_host_model.write(serdes_pkg::ADDR_TX_DATA, v);
        rd_chk(FL, fl(0, 1, 0, 0));
        chk({7'h0, irq}, 8'h00);
        rd_chk(FL, fl(0, 0, 0, 0));
        for (int i = 0; i < 4; i++) strobe(d[i], q[i]);
        i_host_model.write(serdes_pkg::ADDR_TX_MASK, 8'h0f);
        for (int i = 0; i < 4; i++) strobe(v[i], q[i]);
        chk({7'h0, irq}, 8'h01);
        rd_chk(FL, fl(0, 0, 1, 1));
        rd_chk(FL, fl(0, 0, 0, 1));
        @(negedge clk_sys_i) bit_en_i = 1'b1;
        @(negedge clk_sys_i) bit_en_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rd_chk(FL, fl(1, 0, 0, 1));
        rd_chk(FL, fl(0, 0, 0, 1));
        tx_mode_i = 1'b0;
        rd_chk(FL, 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("test transmit flags done");
        close_out();
    end
endmodule // serdes_status_tb
